// [rtl/abp_host_end.sv]
// host side: processor bus master, dma master, select decode, vector and buffer glue
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// R1: device drives full word in second cycle
// R2: device acknowledges read in third cycle
// R3: deselect releases data and acknowledge
// R4: host waits until acknowledge arrives; the code gives up after WAIT_LIMIT cycles and reports RSP_ERR
// R5: device latches write word, then acknowledges
// R6: host drops strobes after write acknowledge
// R7: select needs strobes; data outlasts select
// R8: select excludes interrupt acknowledge function code
// R9: device raises irq only, no vector
// R10: vector logic matches level, drives vector
// R11: vector on low byte, upper ignored
// R12: daisy chain resolves same level sources
// R13: dma acknowledge selects; request per transfer
// R14: single address dma ended by ready
// R15: cycle steal or burst by settings
// R16: buffer direction from rw and select
// R17: buffer direction from rw and int_ack_decode
// R18: buffer direction from rw and grant
// R19: delayed address strobe option for select
// R20: device inverts rw while dma master
// R21: dma write data held past acknowledge
// R22: dma acknowledge low strap: byte mode
// R23: device synchronises select and dma acknowledge
module abp_host_end #(
	parameter int DW = abp_pkg::DATA_W,
	parameter bit DLY_AS = 1'b0,
	parameter logic [abp_pkg::CNT_W-1:0] WAIT_LIMIT = abp_pkg::WAIT_LIMIT_DEF
) (
	input wire logic CLK,
	input wire logic RSTN,
	input wire logic CE,
	abp_bus_if.host BUS,
	input wire logic REQ_VALID,
	output logic REQ_READY,
	input wire logic REQ_WRITE,
	input wire logic [DW-1:0] REQ_WDATA,
	output logic RSP_VALID,
	output logic [DW-1:0] RSP_DATA,
	output logic RSP_ERR,
	output logic RSP_DMA,
	output logic RSP_VEC,
	input wire logic DMA_EN,
	input wire logic DMA_BURST,
	input wire logic DMA_TO_DEV,
	input wire logic [DW-1:0] DMA_WORD,
	output logic DMA_TAKE,
	input wire logic INT_EN,
	input wire logic [2:0] LEVEL_SWITCH,
	input wire logic [7:0] VECTOR_SWITCH,
	input wire logic CHAIN_IN_N,
	output logic CHAIN_OUT_N,
	output logic [2:0] PRIORITY_LEVEL_N,
	output logic GRANT_ACK_N,
	output logic BUF_DIR
);
	import abp_pkg::*;
	abp_host_st_t st_r;
	logic [CNT_W-1:0] cnt_r;
	logic as_n_r;
	logic as_d_r;
	logic uds_n_r;
	logic lds_n_r;
	logic rw_r;
	logic int_ack_decode_r;
	logic err_r;
	logic cs_n_r;
	logic dma_ack_n_n_r;
	logic [2:0] fc_r;
	logic [2:0] lvl_r;
	logic [DW-1:0] hd_r;
	logic hd_oe_n_r;
	logic vec_ack_r;
	logic int_ack_decode_dec;
	logic vec_hit;
	logic ack_seen;
	logic strb_ok;
	assign int_ack_decode_dec = (fc_r == FC_INT_ACK_DECODE) && !as_n_r;
	assign vec_hit = int_ack_decode_dec && (lvl_r == LEVEL_SWITCH) && !CHAIN_IN_N && !BUS.irq_n;
	assign ack_seen = int_ack_decode_r ? vec_ack_r : !BUS.transfer_ack_n;
	assign strb_ok = DLY_AS ? !as_d_r : (!uds_n_r || !lds_n_r);
	assign BUS.cs_n = cs_n_r;
	assign BUS.dma_ack_n = dma_ack_n_n_r;
	assign BUS.rw = rw_r;
	assign BUS.function_code_0 = fc_r[0];
	assign BUS.function_code_1 = fc_r[1];
	assign BUS.function_code_2 = fc_r[2];
	assign BUS.address_strobe_n = as_n_r;
	assign BUS.upper_byte_strobe_n = uds_n_r;
	assign BUS.lower_byte_strobe_n = lds_n_r;
	assign BUS.level_addr = lvl_r;
	assign BUS.host_data = hd_r;
	assign BUS.host_data_oe_n = hd_oe_n_r;
	always_ff @(posedge CLK) begin
		if (!RSTN) begin
			st_r <= HS_IDLE;
			cnt_r <= '0;
			as_n_r <= 1'b1;
			uds_n_r <= 1'b1;
			lds_n_r <= 1'b1;
			rw_r <= 1'b1;
			int_ack_decode_r <= 1'b0;
			err_r <= 1'b0;
			dma_ack_n_n_r <= 1'b1;
			fc_r <= FC_SUP_DATA;
			lvl_r <= '0;
			hd_r <= '1;
			hd_oe_n_r <= 1'b1;
			REQ_READY <= 1'b0;
			RSP_VALID <= 1'b0;
			RSP_DATA <= '0;
			RSP_ERR <= 1'b0;
			RSP_DMA <= 1'b0;
			RSP_VEC <= 1'b0;
			DMA_TAKE <= 1'b0;
			GRANT_ACK_N <= 1'b1;
		end else if (CE) begin
			RSP_VALID <= 1'b0;
			DMA_TAKE <= 1'b0;
			case (st_r)
				HS_IDLE: begin
					err_r <= 1'b0;
					if (REQ_VALID && REQ_READY) begin
						st_r <= HS_ADDR;
						REQ_READY <= 1'b0;
						int_ack_decode_r <= 1'b0;
						rw_r <= !REQ_WRITE;
						fc_r <= FC_SUP_DATA;
						lvl_r <= '0;
						hd_r <= REQ_WDATA;
						hd_oe_n_r <= !REQ_WRITE;
					end else if (!BUS.dma_request_n && DMA_EN) begin
						st_r <= HS_GRANT; // [R13]
						REQ_READY <= 1'b0;
					end else if (PRIORITY_LEVEL_N != LVL_NONE_N) begin
						st_r <= HS_ADDR;
						REQ_READY <= 1'b0;
						int_ack_decode_r <= 1'b1;
						rw_r <= 1'b1;
						fc_r <= FC_INT_ACK_DECODE; // [R10]
						lvl_r <= ~PRIORITY_LEVEL_N;
						hd_oe_n_r <= 1'b1;
					end else begin
						REQ_READY <= 1'b1;
					end
				end
				HS_ADDR: begin
					as_n_r <= 1'b0;
					st_r <= HS_STRB;
				end
				HS_STRB: begin
					uds_n_r <= 1'b0; // [R11]
					lds_n_r <= 1'b0;
					cnt_r <= '0;
					st_r <= HS_WAIT;
				end
				HS_WAIT: begin
					if (int_ack_decode_r && vec_hit) begin
						hd_r <= {{(DW-8){1'b1}}, VECTOR_SWITCH}; // [R10] [R11]
						hd_oe_n_r <= 1'b0;
					end
					if (ack_seen) begin
						RSP_DATA <= BUS.data;
						st_r <= HS_REL;
					end else if (cnt_r == WAIT_LIMIT) begin
						err_r <= 1'b1;
						st_r <= HS_REL;
					end else begin
						cnt_r <= cnt_r + CNT_ONE; // [R4]
					end
				end
				HS_REL: begin
					as_n_r <= 1'b1; // [R6]
					uds_n_r <= 1'b1; // [R6]
					lds_n_r <= 1'b1; // [R6]
					cnt_r <= '0;
					st_r <= HS_HOLD;
				end
				HS_HOLD: begin
					if (cnt_r != HOLD_CYC) begin
						cnt_r <= cnt_r + CNT_ONE;
					end
					// write data stays until select is seen high and the hold has run out
					if (cnt_r >= HOLD_CYC - CNT_ONE && cs_n_r && BUS.transfer_ack_n && !vec_ack_r) begin
						hd_oe_n_r <= 1'b1; // [R6] [R7]
						RSP_VALID <= 1'b1;
						RSP_ERR <= err_r;
						RSP_DMA <= 1'b0;
						RSP_VEC <= int_ack_decode_r;
						int_ack_decode_r <= 1'b0;
						fc_r <= FC_SUP_DATA;
						st_r <= HS_IDLE;
					end
				end
				HS_GRANT: begin
					GRANT_ACK_N <= 1'b0;
					rw_r <= DMA_TO_DEV; // [R20]
					hd_r <= DMA_WORD;
					hd_oe_n_r <= !DMA_TO_DEV;
					DMA_TAKE <= DMA_TO_DEV;
					dma_ack_n_n_r <= 1'b0; // [R14]
					cnt_r <= '0;
					st_r <= HS_DMA_ACK_N;
				end
				HS_DMA_ACK_N: begin
					if (!BUS.transfer_ack_n) begin
						RSP_DATA <= BUS.data;
						dma_ack_n_n_r <= 1'b1; // [R14]
						cnt_r <= '0;
						st_r <= HS_DREL;
					end else if (cnt_r == WAIT_LIMIT) begin
						err_r <= 1'b1;
						dma_ack_n_n_r <= 1'b1;
						cnt_r <= '0;
						st_r <= HS_DREL;
					end else begin
						cnt_r <= cnt_r + CNT_ONE;
					end
				end
				HS_DREL: begin
					if (cnt_r != HOLD_CYC) begin
						cnt_r <= cnt_r + CNT_ONE;
					end
					if (cnt_r >= HOLD_CYC - CNT_ONE && BUS.transfer_ack_n) begin
						hd_oe_n_r <= 1'b1; // [R21]
						RSP_VALID <= 1'b1;
						RSP_ERR <= err_r;
						RSP_DMA <= 1'b1;
						RSP_VEC <= 1'b0;
						err_r <= 1'b0;
						if (DMA_BURST && DMA_EN && !BUS.dma_request_n) begin
							st_r <= HS_GRANT; // [R15]
						end else begin
							GRANT_ACK_N <= 1'b1; // [R15]
							st_r <= HS_IDLE;
						end
					end
				end
				default: st_r <= HS_IDLE;
			endcase
		end
	end
	// select is registered from strobe state, so it always trails the strobes by one edge
	always_ff @(posedge CLK) begin
		if (!RSTN) begin
			as_d_r <= 1'b1;
			cs_n_r <= 1'b1;
		end else if (CE) begin
			as_d_r <= as_n_r; // [R19]
			cs_n_r <= !(!as_n_r && strb_ok && fc_r != FC_INT_ACK_DECODE && GRANT_ACK_N); // [R7] [R8] [R19]
		end
	end
	// interrupt level presentation, vector acknowledge and chain
	always_ff @(posedge CLK) begin
		if (!RSTN) begin
			PRIORITY_LEVEL_N <= LVL_NONE_N;
			vec_ack_r <= 1'b0;
			CHAIN_OUT_N <= 1'b1;
		end else if (CE) begin
			PRIORITY_LEVEL_N <= (INT_EN && !BUS.irq_n) ? ~LEVEL_SWITCH : LVL_NONE_N; // [R9] [R10]
			// acknowledge only once the vector already stands on the bus, else the host latches ones
			vec_ack_r <= vec_hit && !hd_oe_n_r; // [R10]
			CHAIN_OUT_N <= !(int_ack_decode_dec && !CHAIN_IN_N && !vec_hit); // [R12]
		end
	end
	always_ff @(posedge CLK) begin
		if (!RSTN) begin
			BUF_DIR <= 1'b0;
		end else if (CE) begin
			BUF_DIR <= rw_r && (!cs_n_r || int_ack_decode_dec || !GRANT_ACK_N); // [R16] [R17] [R18]
		end
	end
endmodule : abp_host_end
`default_nettype wire

// [rtl/abp_pkg.sv]
// shared constants and state types for the asynchronous host bus port
package abp_pkg;
	localparam int DATA_W = 16;
	localparam int CNT_W = 8;
	localparam logic [CNT_W-1:0] WAIT_LIMIT_DEF = 8'h40;
	localparam logic [CNT_W-1:0] HOLD_CYC = 8'h04;
	localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;
	localparam logic [2:0] FC_SUP_DATA = 3'h5;
	localparam logic [2:0] FC_INT_ACK_DECODE = 3'h7;
	localparam logic [2:0] LVL_NONE_N = 3'h7;
	localparam logic [1:0] SYNC_IDLE = 2'h3;
	typedef enum logic [4:0] {
		DS_IDLE = 5'h01,
		DS_T1 = 5'h02,
		DS_T2 = 5'h04,
		DS_T3 = 5'h08,
		DS_HOLD = 5'h10
	} abp_dev_st_t;
	typedef enum logic [8:0] {
		HS_IDLE = 9'h001,
		HS_ADDR = 9'h002,
		HS_STRB = 9'h004,
		HS_WAIT = 9'h008,
		HS_REL = 9'h010,
		HS_HOLD = 9'h020,
		HS_GRANT = 9'h040,
		HS_DMA_ACK_N = 9'h080,
		HS_DREL = 9'h100
	} abp_host_st_t;
endpackage : abp_pkg

// [rtl/abp_bus_if.sv]
// bus wires between the display controller port and the host side
`timescale 1ns/1ps
`default_nettype none
interface abp_bus_if #(parameter int DW = abp_pkg::DATA_W);
	logic cs_n;
	logic dma_ack_n;
	logic dma_request_n;
	logic rw;
	logic function_code_0;
	logic function_code_1;
	logic function_code_2;
	logic address_strobe_n;
	logic upper_byte_strobe_n;
	logic lower_byte_strobe_n;
	logic [2:0] level_addr;
	logic [DW-1:0] host_data;
	logic host_data_oe_n;
	logic [DW-1:0] dev_data;
	logic dev_data_oe_n;
	logic [DW-1:0] data;
	logic transfer_ack_n;
	logic irq_n;
	// undriven bus floats high
	assign data = !dev_data_oe_n ? dev_data : (!host_data_oe_n ? host_data : '1);
	modport dev (
		input cs_n, dma_ack_n, rw, data,
		output dev_data, dev_data_oe_n, transfer_ack_n, dma_request_n, irq_n
	);
	modport host (
		output cs_n, dma_ack_n, rw, function_code_0, function_code_1, function_code_2,
		output address_strobe_n, upper_byte_strobe_n, lower_byte_strobe_n, level_addr,
		output host_data, host_data_oe_n,
		input data, transfer_ack_n, dma_request_n, irq_n
	);
endinterface : abp_bus_if
`default_nettype wire

// [rtl/abp_dev_end.sv]
// controller side of the host bus port: select, access sequence, dma request, irq
`timescale 1ns/1ps
`default_nettype none
module abp_dev_end #(
	parameter int DW = abp_pkg::DATA_W
) (
	input wire logic CLK,
	input wire logic RSTN,
	input wire logic CE,
	abp_bus_if.dev BUS,
	input wire logic [DW-1:0] RD_WORD,
	output logic RD_TAKE,
	output logic [DW-1:0] WR_WORD,
	output logic WR_VALID,
	output logic WR_DMA,
	input wire logic IRQ_REQ,
	input wire logic DMA_WANT,
	input wire logic DMA_BURST,
	output logic BYTE_MODE
);
	import abp_pkg::*;
	abp_dev_st_t st_r;
	logic [1:0] cs_sync_r;
	logic [1:0] dk_sync_r;
	logic strap_done_r;
	logic rd_r;
	logic dma_r;
	logic d_oe_n_r;
	logic [DW-1:0] d_out_r;
	logic ack_n_r;
	logic dma_request_n_n_r;
	logic irq_n_r;
	logic sel;
	logic dma_sel;
	assign sel = !cs_sync_r[1] || !dk_sync_r[1];
	assign dma_sel = !dk_sync_r[1];
	assign BUS.dev_data = d_out_r;
	assign BUS.dev_data_oe_n = d_oe_n_r;
	assign BUS.transfer_ack_n = ack_n_r;
	assign BUS.dma_request_n = dma_request_n_n_r;
	assign BUS.irq_n = irq_n_r;
	// nothing but stage 1 reads stage 0, so a metastable first stage never reaches the logic
	always_ff @(posedge CLK) begin
		if (!RSTN) begin
			cs_sync_r <= SYNC_IDLE;
			dk_sync_r <= SYNC_IDLE;
		end else if (CE) begin
			cs_sync_r <= {cs_sync_r[0], BUS.cs_n}; // [R23]
			dk_sync_r <= {dk_sync_r[0], BUS.dma_ack_n}; // [R23]
		end
	end
	// strap taken on the first enabled edge after reset release
	always_ff @(posedge CLK) begin
		if (!RSTN) begin
			strap_done_r <= 1'b0;
			BYTE_MODE <= 1'b0;
		end else if (CE && !strap_done_r) begin
			strap_done_r <= 1'b1;
			BYTE_MODE <= !BUS.dma_ack_n; // [R22]
		end
	end
	always_ff @(posedge CLK) begin
		if (!RSTN) begin
			st_r <= DS_IDLE;
			rd_r <= 1'b0;
			dma_r <= 1'b0;
		end else if (CE) begin
			case (st_r)
				DS_IDLE: begin
					if (sel) begin
						st_r <= DS_T1;
						dma_r <= dma_sel; // [R13]
						rd_r <= dma_sel ? !BUS.rw : BUS.rw; // [R20]
					end
				end
				DS_T1: st_r <= sel ? DS_T2 : DS_IDLE;
				DS_T2: st_r <= sel ? DS_T3 : DS_IDLE;
				DS_T3: st_r <= sel ? DS_HOLD : DS_IDLE;
				DS_HOLD: begin
					if (!sel) begin
						st_r <= DS_IDLE; // [R3]
					end
				end
				default: st_r <= DS_IDLE;
			endcase
		end
	end
	// data lanes and acknowledge
	always_ff @(posedge CLK) begin
		if (!RSTN) begin
			d_out_r <= '1;
			d_oe_n_r <= 1'b1;
			ack_n_r <= 1'b1;
			WR_WORD <= '0;
			WR_VALID <= 1'b0;
			WR_DMA <= 1'b0;
			RD_TAKE <= 1'b0;
		end else if (CE) begin
			WR_VALID <= 1'b0;
			RD_TAKE <= 1'b0;
			if (!sel) begin
				d_oe_n_r <= 1'b1; // [R3]
				ack_n_r <= 1'b1; // [R3]
				if (dma_r && !rd_r && (st_r == DS_HOLD || st_r == DS_T3)) begin
					WR_WORD <= BUS.data; // [R21]
					WR_VALID <= 1'b1;
					WR_DMA <= 1'b1;
				end
			end else if (st_r == DS_T2) begin
				if (rd_r) begin
					d_out_r[DW/2-1:0] <= RD_WORD[DW/2-1:0]; // [R1]
					d_out_r[DW-1:DW/2] <= BYTE_MODE ? '1 : RD_WORD[DW-1:DW/2]; // [R22]
					d_oe_n_r <= 1'b0; // [R1]
					RD_TAKE <= 1'b1;
				end else if (!dma_r) begin
					WR_WORD <= BUS.data; // [R5]
					WR_VALID <= 1'b1;
					WR_DMA <= 1'b0;
				end
			end else if (st_r == DS_T3) begin
				ack_n_r <= 1'b0; // [R2] [R5] [R14]
			end
		end
	end
	// cycle steal drops the request while acknowledged; burst keeps it up
	always_ff @(posedge CLK) begin
		if (!RSTN) begin
			dma_request_n_n_r <= 1'b1;
		end else if (CE) begin
			dma_request_n_n_r <= !(DMA_WANT && (DMA_BURST || (!dma_sel && st_r == DS_IDLE))); // [R13] [R15]
		end
	end
	always_ff @(posedge CLK) begin
		if (!RSTN) begin
			irq_n_r <= 1'b1;
		end else if (CE) begin
			irq_n_r <= !IRQ_REQ; // [R9]
		end
	end
endmodule : abp_dev_end
`default_nettype wire

// [dv/abp_bus_properties.sv]
// concurrent checks on the wires between the device end and the host end
`timescale 1ns/1ps
`default_nettype none
module abp_bus_properties (
	input wire logic CLK,
	input wire logic RSTN,
	input wire logic cs_n,
	input wire logic dma_ack_n,
	input wire logic dma_request_n,
	input wire logic rw,
	input wire logic function_code_0,
	input wire logic function_code_1,
	input wire logic function_code_2,
	input wire logic address_strobe_n,
	input wire logic host_data_oe_n,
	input wire logic dev_data_oe_n,
	input wire logic transfer_ack_n
);
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RSTN);
	// two sync stages and the access cycles keep the acknowledge off for six edges
	sequence sel_wait_s;
		transfer_ack_n [*5] ##[1:2] !transfer_ack_n;
	endsequence
	sequence ack_fall_s;
		$fell(transfer_ack_n);
	endsequence
	cpu_ack_time_a: assert property ($fell(cs_n) |-> sel_wait_s)
		else $error("cpu acknowledge off time");
	dma_ack_time_a: assert property ($fell(dma_ack_n) |-> sel_wait_s)
		else $error("dma acknowledge off time");
	rd_data_first_a: assert property (ack_fall_s |-> cs_n || !rw || !$past(dev_data_oe_n))
		else $error("read data not ahead of acknowledge");
	cpu_dir_a: assert property (ack_fall_s |-> cs_n || (dev_data_oe_n == !rw))
		else $error("cpu data direction wrong");
	dma_dir_a: assert property (ack_fall_s |-> dma_ack_n || (dev_data_oe_n == rw))
		else $error("dma data direction wrong");
	ack_selected_a: assert property (ack_fall_s |-> !cs_n || !dma_ack_n)
		else $error("acknowledge without select");
	release_time_a: assert property ($rose(cs_n) |-> ##[1:4] transfer_ack_n && dev_data_oe_n)
		else $error("deselect not released");
	sel_strobe_a: assert property ($fell(cs_n) |-> !address_strobe_n)
		else $error("select without strobe");
	int_ack_decode_no_sel_a: assert property ({function_code_2, function_code_1, function_code_0}
		== abp_pkg::FC_INT_ACK_DECODE |-> cs_n && dev_data_oe_n) else $error("device in int_ack_decode cycle");
	cpu_data_hold_a: assert property ($rose(cs_n) && !rw |-> !host_data_oe_n [*3])
		else $error("write data dropped early");
	dma_data_hold_a: assert property ($rose(dma_ack_n) && rw |-> !host_data_oe_n [*3])
		else $error("dma data dropped early");
	// the host samples the request one edge before the acknowledge falls, two before $fell sees it
	dma_req_first_a: assert property ($fell(dma_ack_n) |-> !$past(dma_request_n, 2))
		else $error("dma acknowledge without request");
endmodule : abp_bus_properties
`default_nettype wire

// [dv/tb.sv]
// self-checking bench joining the device end and the host end of the bus port
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin errors++; \
	$display("[ERR] %0t got %h want %h", $time, a, e); end end
module tb;
	import abp_pkg::*;
	logic clk, rstn, req_valid, req_ready, req_write, rsp_valid, rsp_err, rsp_dma, rsp_vec;
	logic dma_en, h_burst, to_dev, dma_take, int_en, chain_in_n, chain_out_n, grant_ack_n;
	logic buf_dir, rd_take, wr_valid, wr_dma, irq_req, dma_want, d_burst, byte_mode;
	logic [DATA_W-1:0] wdata, rsp_data, dma_word, rd_word, wr_word;
	logic [2:0] level_sw, prio_n;
	logic [7:0] vec_sw;
	logic [DATA_W-1:0] pat [3] = '{16'hffff, 16'h0000, 16'ha5c3};
	int errors, tests_run;
	int n_wr, n_rd, n_take, n_dir, n_chain, base;
	abp_bus_if bus_if();
	abp_dev_end abp_dev_end_inst (.CLK(clk), .RSTN(rstn), .CE(1'b1), .BUS(bus_if),
		.RD_WORD(rd_word), .RD_TAKE(rd_take), .WR_WORD(wr_word), .WR_VALID(wr_valid),
		.WR_DMA(wr_dma), .IRQ_REQ(irq_req), .DMA_WANT(dma_want), .DMA_BURST(d_burst),
		.BYTE_MODE(byte_mode));
	// short wait limit keeps the unanswered int_ack_decode case brief
	abp_host_end #(.WAIT_LIMIT(8'h10)) abp_host_end_inst (.CLK(clk), .RSTN(rstn), .CE(1'b1),
		.BUS(bus_if), .REQ_VALID(req_valid), .REQ_READY(req_ready), .REQ_WRITE(req_write),
		.REQ_WDATA(wdata), .RSP_VALID(rsp_valid), .RSP_DATA(rsp_data), .RSP_ERR(rsp_err),
		.RSP_DMA(rsp_dma), .RSP_VEC(rsp_vec), .DMA_EN(dma_en), .DMA_BURST(h_burst),
		.DMA_TO_DEV(to_dev), .DMA_WORD(dma_word), .DMA_TAKE(dma_take), .INT_EN(int_en),
		.LEVEL_SWITCH(level_sw), .VECTOR_SWITCH(vec_sw), .CHAIN_IN_N(chain_in_n),
		.CHAIN_OUT_N(chain_out_n), .PRIORITY_LEVEL_N(prio_n), .GRANT_ACK_N(grant_ack_n),
		.BUF_DIR(buf_dir));
	abp_bus_properties abp_bus_properties_inst (.CLK(clk), .RSTN(rstn), .cs_n(bus_if.cs_n),
		.dma_ack_n(bus_if.dma_ack_n), .dma_request_n(bus_if.dma_request_n), .rw(bus_if.rw),
		.function_code_0(bus_if.function_code_0), .function_code_1(bus_if.function_code_1),
		.function_code_2(bus_if.function_code_2), .address_strobe_n(bus_if.address_strobe_n),
		.host_data_oe_n(bus_if.host_data_oe_n), .dev_data_oe_n(bus_if.dev_data_oe_n),
		.transfer_ack_n(bus_if.transfer_ack_n));
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	// pulses are counted on the falling edge, where they stand settled
	always @(negedge clk) begin
		if (wr_valid === 1'b1)
			n_wr++;
		if (rd_take === 1'b1)
			n_rd++;
		if (dma_take === 1'b1)
			n_take++;
		if (buf_dir === 1'b1)
			n_dir++;
		if (chain_out_n === 1'b0)
			n_chain++;
	end
	task automatic wait_rsp;
		int n;
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (!rsp_valid && n < 300);
		`CHK(rsp_valid, 1'b1)
	endtask : wait_rsp
	// stray int_ack_decode or burst cycles must finish before the next scenario
	task automatic wait_idle;
		int k;
		k = 0;
		for (int n = 0; n < 400 && k < 8; n++) begin
			@(negedge clk);
			k = (grant_ack_n && req_ready) ? k + 1 : 0;
		end
		`CHK(k, 8)
	endtask : wait_idle
	task automatic host_op(input logic wr, input logic [DATA_W-1:0] v);
		wait_idle();
		req_write = wr;
		wdata = v;
		req_valid = 1'b1;
		@(negedge clk);
		req_valid = 1'b0;
		wait_rsp();
	endtask : host_op
	task automatic end_test(input string s);
		$display("test %s done", s);
	endtask : end_test
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : print_verdict
	initial begin
		repeat (30000) @(posedge clk);
		errors++;
		print_verdict();
	end
	initial begin
		{rstn, req_valid, req_write, dma_en, h_burst, to_dev, int_en, irq_req} = '0;
		{dma_want, d_burst, chain_in_n} = 3'h1;
		{wdata, dma_word, rd_word} = '0;
		level_sw = 3'h5;
		vec_sw = 8'h7c;
		repeat (16) @(negedge clk);
		rstn = 1'b1;
		foreach (pat[i]) begin
			host_op(1'b1, pat[i]);
			`CHK(rsp_err, 1'b0)
			`CHK(wr_word, pat[i])
			`CHK(wr_dma, 1'b0)
		end
		`CHK(byte_mode, 1'b0)
		`CHK(n_wr, 3)
		`CHK(n_dir, 0)
		end_test("cpu write");
		foreach (pat[i]) begin
			rd_word = pat[i];
			host_op(1'b0, 16'h0000);
			`CHK(rsp_data, pat[i])
		end
		`CHK(n_rd, 3)
		`CHK(n_dir > 0, 1'b1)
		end_test("cpu read");
		irq_req = 1'b1;
		repeat (3) @(negedge clk);
		`CHK(bus_if.irq_n, 1'b0)
		`CHK(prio_n, 3'h7)
		chain_in_n = 1'b1;
		int_en = 1'b1;
		wait_rsp();
		`CHK(rsp_err, 1'b1)
		`CHK(n_chain, 0)
		chain_in_n = 1'b0;
		wait_rsp();
		irq_req = 1'b0;
		int_en = 1'b0;
		`CHK(rsp_vec, 1'b1)
		`CHK(rsp_data[7:0], vec_sw)
		// the level is still presented for one more cycle; with the source gone it is passed on
		wait_idle();
		`CHK(n_chain > 0, 1'b1)
		end_test("interrupt");
		wait_idle();
		dma_en = 1'b1;
		for (int m = 0; m < 2; m++) begin
			{d_burst, h_burst, to_dev} = {m[0], m[0], 1'b1};
			dma_word = 16'h3c5a ^ 16'(m);
			base = n_take;
			dma_want = 1'b1;
			wait_rsp();
			dma_want = 1'b0;
			`CHK(rsp_dma, 1'b1)
			`CHK(wr_word, dma_word)
			`CHK(wr_dma, 1'b1)
			`CHK(n_take > base, 1'b1)
			wait_idle();
			to_dev = 1'b0;
			rd_word = 16'h9e01 ^ 16'(m);
			dma_want = 1'b1;
			wait_rsp();
			dma_want = 1'b0;
			`CHK(rsp_data, rd_word)
			wait_idle();
		end
		dma_en = 1'b0;
		end_test("dma");
		print_verdict();
	end
endmodule : tb
`default_nettype wire
